// File: design/pll_cfg_pkg.sv
`default_nettype none
package pll_cfg_pkg;
   // =========================================
   // Bus
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;
   localparam int AXI_SW = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // =========================================
   // Register offsets
   localparam logic [7:0] OFS_PRESCALE = 8'h00;
   localparam logic [7:0] OFS_LOOP = 8'h04;
   localparam logic [7:0] OFS_REFDIV = 8'h08;
   localparam logic [7:0] OFS_FBDIV = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam int CFG_REGS = 4;
   // =========================================
   // Field positions and widths
   localparam int PRESCALE_BIT = 15;
   localparam int CAP_LSB = 4;
   localparam int CAP_W = 4;
   localparam int R3_LSB = 8;
   localparam int R4_LSB = 11;
   localparam int RES_W = 3;
   localparam int RATE_LSB = 14;
   localparam int RATE_W = 8;
   localparam int RDIV_LSB = 8;
   localparam int RDIV_W = 12;
   localparam int MUX_LSB = 20;
   localparam int MUX_W = 4;
   localparam int SLEEP_BIT = 26;
   localparam int GLOBAL_BIT = 27;
   localparam int FOUT_BIT = 28;
   localparam int NDIV_LSB = 8;
   localparam int NDIV_W = 18;
   localparam int PDIV_LSB = 26;
   localparam int PDIV_W = 4;
   // =========================================
   // Reset values and limits
   localparam logic [7:0] RATE_RST = 8'h0A;
   localparam logic [11:0] RDIV_RST = 12'h00A;
   localparam logic [17:0] NDIV_RST = 18'h002F8;
   localparam logic [3:0] PDIV_RST = 4'h2;
   localparam logic [3:0] CAP_MAX = 4'hB;
   localparam logic [2:0] RES_MAX = 3'h4;
   localparam logic [7:0] RATE_MAX = 8'hC8;
   localparam logic [3:0] PDIV_MIN = 4'h2;
   localparam logic [3:0] PDIV_MAX = 4'h8;
   localparam logic [5:0] RES_STEP_KOHM = 6'h0A;
   localparam logic [1:0] LD_PRESCALE_LAST = 2'h3;
   localparam logic [31:0] LOOP_RST = {10'h0, RATE_RST, 14'h0};
   localparam logic [31:0] REFDIV_RST = {4'h0, 1'b1, 7'h0, RDIV_RST, 8'h0};
   localparam logic [31:0] FBDIV_RST = {2'h0, PDIV_RST, NDIV_RST, 8'h0};
   // =========================================
   // Lock pin modes
   localparam logic [3:0] LK_HIZ = 4'h0;
   localparam logic [3:0] LK_HIGH = 4'h1;
   localparam logic [3:0] LK_LOW = 4'h2;
   localparam logic [3:0] LK_DL_HI = 4'h3;
   localparam logic [3:0] LK_DL_LO = 4'h4;
   localparam logic [3:0] LK_AL_PP = 4'h5;
   localparam logic [3:0] LK_AL_NMOS = 4'h6;
   localparam logic [3:0] LK_AL_PMOS = 4'h7;
   localparam logic [3:0] LK_N_HALF = 4'h9;
   localparam logic [3:0] LK_R_HALF = 4'hB;
   // =========================================
   // Status bits and timing
   localparam int ST_CAL = 0;
   localparam int ST_DLOCK = 1;
   localparam int ST_ALOCK = 2;
   localparam int ST_BAD = 8;
   localparam int CLK_MHZ = 250;
   localparam int CAL_TIME_US = 4;
   localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ;
   typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_t;
endpackage : pll_cfg_pkg
`default_nettype wire

// File: design/pll_cfg_ctrl.sv
// Function
// - Prescale bit divides lock detector rate by four
// - Capacitor code decodes twelve pairings, reset zero
// - Third pole resistor code zero low, 1-4
// - Fourth pole resistor code zero low, 1-4
// - Reference divider binary ratio, reset ten
// - Feedback register write starts frequency calibration
// - Lock pin modes: hi-z, high, low, analog
// - Codes three/four give digital lock, both polarities
// - Codes nine/eleven give halved divider outputs
// - Sleep bit shuts every block down
// - Global enable zero turns all outputs but the raw oscillator port off
// - Raw oscillator port enabled only by bit
// - Feedback divider binary ratio, reset 760
// - Feedback divider follows post-divider, feeds detector
// - Post-divider ratios two to eight, reset two
// - Post-divider output feeds every distribution block
// - Low gate pin disables every clock output but the raw oscillator port
`timescale 1ns/1ns
`default_nettype none
module pll_cfg_ctrl #(
   parameter int CAL_CYCLES_P = pll_cfg_pkg::CAL_CYCLES,
   parameter int LOCK_SAMPLES = 16
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // AXI4-Lite write
   input wire logic [pll_cfg_pkg::AXI_AW-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [pll_cfg_pkg::AXI_DW-1:0] i_wdata,
   input wire logic [pll_cfg_pkg::AXI_SW-1:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // AXI4-Lite read
   input wire logic [pll_cfg_pkg::AXI_AW-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [pll_cfg_pkg::AXI_DW-1:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Pins in
   input wire logic i_reference_input,
   input wire logic i_osc_pin,
   input wire logic i_output_gate_pin,
   input wire logic i_analog_lock,
   // Lock pin
   output logic o_lock_pin,
   output logic o_lock_pin_oe_n,
   // Clock path and power
   output logic o_dist_tick,
   output logic o_outputs_on,
   output logic o_fout_on,
   output logic o_device_sleep,
   output logic o_cal_busy,
   // Loop filter settings
   output logic [7:0] o_cap_c3_pf,
   output logic [7:0] o_cap_c4_pf,
   output logic [5:0] o_r3_kohm,
   output logic [5:0] o_r4_kohm,
   output logic [7:0] o_reference_rate_mhz
);
   import pll_cfg_pkg::*;

   initial begin
      if (CAL_CYCLES_P < 3 || CAL_CYCLES_P > 65535 ||
          LOCK_SAMPLES < 1 || LOCK_SAMPLES > 255) begin
         $error("pll_cfg_ctrl: parameter out of range");
      end
   end

   // =========================================
   // Register bus
   logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
   logic [AXI_AW-1:0] awaddr_r;
   logic [AXI_DW-1:0] wdata_r, rdata_r;
   logic [AXI_SW-1:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] cfg_r [CFG_REGS];
   logic [31:0] wr_word;

   wire aw_hs = i_awvalid && o_awready;
   wire w_hs = i_wvalid && o_wready;
   wire aw_have = aw_got_r || aw_hs;
   wire w_have = w_got_r || w_hs;
   wire wr_fire = aw_have && w_have;
   wire [AXI_AW-1:0] wr_addr = aw_got_r ? awaddr_r : i_awaddr;
   wire [AXI_DW-1:0] wr_data = w_got_r ? wdata_r : i_wdata;
   wire [AXI_SW-1:0] wr_strb = w_got_r ? wstrb_r : i_wstrb;
   wire [1:0] wr_idx = wr_addr[3:2];
   wire wr_cfg = (wr_addr[AXI_AW-1:4] == '0) && (wr_addr[1:0] == 2'h0);
   wire wr_commit = wr_fire && wr_cfg;
   wire wr_fb = wr_commit && (wr_addr == OFS_FBDIV);
   wire ar_hs = i_arvalid && o_arready;
   wire rd_cfg = (i_araddr[AXI_AW-1:4] == '0) && (i_araddr[1:0] == 2'h0);
   wire rd_stat = (i_araddr == OFS_STATUS);

   assign o_awready = !aw_got_r && !bvalid_r;
   assign o_wready = !w_got_r && !bvalid_r;
   assign o_arready = !rvalid_r;
   assign o_bvalid = bvalid_r;
   assign o_bresp = bresp_r;
   assign o_rvalid = rvalid_r;
   assign o_rdata = rdata_r;
   assign o_rresp = rresp_r;

   // Byte lane merge into the stored word
   always_comb begin
      wr_word = cfg_r[wr_idx];
      for (int b = 0; b < AXI_SW; b++) begin
         if (wr_strb[b]) begin
            wr_word[8*b +: 8] = wr_data[8*b +: 8];
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else begin
         if (aw_hs && !wr_fire) begin
            aw_got_r <= 1'b1;
            awaddr_r <= i_awaddr;
         end
         if (w_hs && !wr_fire) begin
            w_got_r <= 1'b1;
            wdata_r <= i_wdata;
            wstrb_r <= i_wstrb;
         end
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_cfg ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && i_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Whole word lands in one edge
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cfg_r[0] <= '0;
         cfg_r[1] <= LOOP_RST;
         cfg_r[2] <= REFDIV_RST;
         cfg_r[3] <= FBDIV_RST;
      end else if (wr_commit) begin
         cfg_r[wr_idx] <= wr_word;
      end
   end

   // =========================================
   // Fields
   wire prescale = cfg_r[0][PRESCALE_BIT];
   wire [CAP_W-1:0] cap_sel = cfg_r[1][CAP_LSB +: CAP_W];
   wire [RES_W-1:0] r3_sel = cfg_r[1][R3_LSB +: RES_W];
   wire [RES_W-1:0] r4_sel = cfg_r[1][R4_LSB +: RES_W];
   wire [RATE_W-1:0] ref_rate = cfg_r[1][RATE_LSB +: RATE_W];
   wire [RDIV_W-1:0] rdiv = cfg_r[2][RDIV_LSB +: RDIV_W];
   wire [MUX_W-1:0] lock_mux = cfg_r[2][MUX_LSB +: MUX_W];
   wire sleep = cfg_r[2][SLEEP_BIT];
   wire all_en = cfg_r[2][GLOBAL_BIT];
   wire fout_en = cfg_r[2][FOUT_BIT];
   wire [NDIV_W-1:0] ndiv = cfg_r[3][NDIV_LSB +: NDIV_W];
   wire [PDIV_W-1:0] pdiv = cfg_r[3][PDIV_LSB +: PDIV_W];

   wire bad_cap = cap_sel > CAP_MAX;
   wire bad_r3 = r3_sel > RES_MAX;
   wire bad_r4 = r4_sel > RES_MAX;
   wire bad_rate = ref_rate == '0 || ref_rate > RATE_MAX;
   wire bad_rdiv = rdiv == '0;
   wire bad_ndiv = ndiv == '0;
   wire bad_pdiv = pdiv < PDIV_MIN || pdiv > PDIV_MAX;
   wire bad_mux = lock_mux == 4'h8 || lock_mux == 4'hA ||
      lock_mux > LK_R_HALF;
   wire [7:0] bad_vec = {bad_mux, bad_pdiv, bad_ndiv, bad_rdiv,
      bad_rate, bad_r4, bad_r3, bad_cap};

   // Capacitor pairings, pF
   localparam logic [7:0] C3_TAB [12] = '{8'h00, 8'h00, 8'h32, 8'h00,
      8'h32, 8'h64, 8'h00, 8'h32, 8'h64, 8'h64, 8'h96, 8'h96};
   localparam logic [7:0] C4_TAB [12] = '{8'h0A, 8'h3C, 8'h0A, 8'h6E,
      8'h6E, 8'h6E, 8'hA0, 8'hA0, 8'h0A, 8'h3C, 8'h6E, 8'h3C};
   wire [3:0] cap_idx = bad_cap ? 4'h0 : cap_sel;
   wire [5:0] r3_k = bad_r3 ? 6'h0 : 6'(r3_sel * RES_STEP_KOHM);
   wire [5:0] r4_k = bad_r4 ? 6'h0 : 6'(r4_sel * RES_STEP_KOHM);

   // =========================================
   // Pin synchronisers and edges
   logic [3:0] sync1_r, sync2_r;
   logic ref_prev_r, osc_prev_r;
   wire ref_s = sync2_r[0];
   wire osc_s = sync2_r[1];
   wire gate_s = sync2_r[2];
   wire alock_s = sync2_r[3];
   wire ref_rise = ref_s && !ref_prev_r;
   wire osc_rise = osc_s && !osc_prev_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         ref_prev_r <= 1'b0;
         osc_prev_r <= 1'b0;
      end else begin
         sync1_r <= {i_analog_lock, i_output_gate_pin, i_osc_pin,
            i_reference_input};
         sync2_r <= sync1_r;
         ref_prev_r <= ref_s;
         osc_prev_r <= osc_s;
      end
   end

   // =========================================
   // Dividers and lock detect
   logic [PDIV_W-1:0] pd_cnt_r;
   logic [NDIV_W-1:0] n_cnt_r;
   logic [RDIV_W-1:0] r_cnt_r;
   logic [1:0] ld_cnt_r;
   logic [7:0] lock_cnt_r;
   logic dist_tick_r, fb_tick_r, ref_tick_r, fb_seen_r;
   logic n_half_r, r_half_r, dlock_r;
   wire pd_end = pd_cnt_r >= pdiv - 4'h1;
   wire n_end = n_cnt_r >= ndiv - 18'h1;
   wire r_end = r_cnt_r >= rdiv - 12'h1;
   wire ld_tick = ref_tick_r && (!prescale ||
      ld_cnt_r == LD_PRESCALE_LAST);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pd_cnt_r <= '0;
         n_cnt_r <= '0;
         r_cnt_r <= '0;
         ld_cnt_r <= '0;
         lock_cnt_r <= '0;
         dist_tick_r <= 1'b0;
         fb_tick_r <= 1'b0;
         ref_tick_r <= 1'b0;
         fb_seen_r <= 1'b0;
         n_half_r <= 1'b0;
         r_half_r <= 1'b0;
         dlock_r <= 1'b0;
      end else if (sleep) begin
         pd_cnt_r <= '0;
         n_cnt_r <= '0;
         r_cnt_r <= '0;
         ld_cnt_r <= '0;
         lock_cnt_r <= '0;
         dist_tick_r <= 1'b0;
         fb_tick_r <= 1'b0;
         ref_tick_r <= 1'b0;
         fb_seen_r <= 1'b0;
         dlock_r <= 1'b0;
      end else begin
         // Post-divider first, always in path
         dist_tick_r <= osc_rise && pd_end;
         if (osc_rise) begin
            pd_cnt_r <= pd_end ? '0 : pd_cnt_r + 4'h1;
         end
         // Feedback divider counts post-divided ticks
         fb_tick_r <= dist_tick_r && n_end;
         if (dist_tick_r) begin
            n_cnt_r <= n_end ? '0 : n_cnt_r + 18'h1;
         end
         ref_tick_r <= ref_rise && r_end;
         if (ref_rise) begin
            r_cnt_r <= r_end ? '0 : r_cnt_r + 12'h1;
         end
         if (fb_tick_r) begin
            n_half_r <= !n_half_r;
         end
         if (ref_tick_r) begin
            r_half_r <= !r_half_r;
            ld_cnt_r <= ld_cnt_r + 2'h1;
         end
         // Lock once enough samples each saw feedback
         if (ld_tick) begin
            fb_seen_r <= fb_tick_r;
            if (fb_seen_r || fb_tick_r) begin
               if (lock_cnt_r < 8'(LOCK_SAMPLES)) begin
                  lock_cnt_r <= lock_cnt_r + 8'h1;
               end
            end else begin
               lock_cnt_r <= '0;
            end
         end else if (fb_tick_r) begin
            fb_seen_r <= 1'b1;
         end
         dlock_r <= lock_cnt_r == 8'(LOCK_SAMPLES);
      end
   end

   // =========================================
   // Frequency calibration
   cal_state_t cal_st_r;
   logic [15:0] cal_cnt_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cal_st_r <= CAL_IDLE;
         cal_cnt_r <= '0;
      end else if (sleep) begin
         cal_st_r <= CAL_IDLE;
         cal_cnt_r <= '0;
      end else if (wr_fb) begin
         cal_st_r <= CAL_RUN;
         cal_cnt_r <= 16'(CAL_CYCLES_P - 1);
      end else begin
         case (cal_st_r)
            CAL_RUN: begin
               if (cal_cnt_r == '0) begin
                  cal_st_r <= CAL_IDLE;
               end else begin
                  cal_cnt_r <= cal_cnt_r - 16'h1;
               end
            end
            default: cal_st_r <= CAL_IDLE;
         endcase
      end
   end

   // =========================================
   // Lock pin, enables and outputs
   logic lk_o, lk_oe_n;
   always_comb begin
      lk_o = 1'b0;
      lk_oe_n = 1'b0;
      case (lock_mux)
         LK_HIGH: lk_o = 1'b1;
         LK_LOW: lk_o = 1'b0;
         LK_DL_HI: lk_o = dlock_r;
         LK_DL_LO: lk_o = !dlock_r;
         LK_AL_PP: lk_o = alock_s;
         LK_AL_NMOS: lk_oe_n = alock_s;
         LK_AL_PMOS: begin
            lk_o = 1'b1;
            lk_oe_n = !alock_s;
         end
         LK_N_HALF: lk_o = n_half_r;
         LK_R_HALF: lk_o = r_half_r;
         default: lk_oe_n = 1'b1;
      endcase
      if (sleep) begin
         lk_o = 1'b0;
         lk_oe_n = 1'b1;
      end
   end

   wire outs_on = all_en && gate_s && !sleep;
   wire fout_on = fout_en && !sleep;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_lock_pin <= 1'b0;
         o_lock_pin_oe_n <= 1'b1;
         o_outputs_on <= 1'b0;
         o_fout_on <= 1'b0;
         o_cap_c3_pf <= '0;
         o_cap_c4_pf <= '0;
         o_r3_kohm <= '0;
         o_r4_kohm <= '0;
         o_reference_rate_mhz <= RATE_RST;
      end else begin
         o_lock_pin <= lk_o;
         o_lock_pin_oe_n <= lk_oe_n;
         o_outputs_on <= outs_on;
         o_fout_on <= fout_on;
         o_cap_c3_pf <= C3_TAB[cap_idx];
         o_cap_c4_pf <= C4_TAB[cap_idx];
         o_r3_kohm <= r3_k;
         o_r4_kohm <= r4_k;
         o_reference_rate_mhz <= ref_rate;
      end
   end

   assign o_dist_tick = dist_tick_r;
   assign o_device_sleep = sleep;
   assign o_cal_busy = cal_st_r == CAL_RUN;

   // Read side: config words are write-only
   wire [31:0] status = {16'h0, bad_vec, 5'h0, alock_s, dlock_r,
      o_cal_busy};
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_stat ? status : '0;
         rresp_r <= (rd_cfg || rd_stat) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && i_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // =========================================
   // Assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_cal_start:
   assert property (wr_fb && !sleep |=> o_cal_busy [*3])
      else $error("calibration did not start on feedback write");
   a_sleep_off:
   assert property (sleep [*2] |-> !o_outputs_on && !o_fout_on &&
      o_lock_pin_oe_n && !o_dist_tick)
      else $error("sleep left a block running");
   a_global_off:
   assert property (!all_en |=> !o_outputs_on)
      else $error("outputs on with global enable low");
   a_gate_off:
   assert property (!gate_s |=> !o_outputs_on)
      else $error("outputs on with gate pin low");
   a_fout_gate:
   assert property (o_fout_on |-> $past(fout_en))
      else $error("raw oscillator port on without enable");
   a_lock_hiz:
   assert property (lock_mux == LK_HIZ && !sleep |=> o_lock_pin_oe_n)
      else $error("lock pin driven in high impedance mode");
   a_dlock_pol:
   assert property (lock_mux == LK_DL_LO && !sleep |=>
      !o_lock_pin_oe_n && o_lock_pin == !$past(dlock_r))
      else $error("digital lock polarity wrong");
   a_prescale_four:
   assert property (prescale && ref_tick_r &&
      ld_cnt_r != LD_PRESCALE_LAST |-> !ld_tick)
      else $error("lock detector not divided by four");
   a_pdiv_space:
   assert property (o_dist_tick |=> !o_dist_tick)
      else $error("post-divider ticks too close");
   a_write_resp:
   assert property (wr_commit |=> o_bvalid &&
      cfg_r[$past(wr_idx)] == $past(wr_word))
      else $error("write not applied with its response");
endmodule : pll_cfg_ctrl
`default_nettype wire

// File: bench/host_axi.sv
`timescale 1ns/1ns
`default_nettype none
module host_axi (
   // Clock
   input wire logic i_clk,
   // Write side
   output logic [7:0] o_awaddr,
   output logic o_awvalid,
   input wire logic i_awready,
   output logic [31:0] o_wdata,
   output logic [3:0] o_wstrb,
   output logic o_wvalid,
   input wire logic i_wready,
   input wire logic [1:0] i_bresp,
   input wire logic i_bvalid,
   output logic o_bready,
   // Read side
   output logic [7:0] o_araddr,
   output logic o_arvalid,
   input wire logic i_arready,
   input wire logic [31:0] i_rdata,
   input wire logic [1:0] i_rresp,
   input wire logic i_rvalid,
   output logic o_rready
);
   initial begin
      {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
      {o_araddr, o_arvalid, o_rready} = '0;
   end

   // ==========
   // Write: both channels offered, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [1:0] r);
      @(posedge i_clk);
      o_awaddr <= a;
      o_wdata <= d;
      o_wstrb <= s;
      {o_awvalid, o_wvalid, o_bready} <= 3'h7;
      do begin
         @(posedge i_clk);
         if (i_awready) o_awvalid <= 1'b0;
         if (i_wready) o_wvalid <= 1'b0;
      end while (o_awvalid && !i_awready || o_wvalid && !i_wready);
      do @(posedge i_clk); while (!i_bvalid);
      r = i_bresp;
      o_bready <= 1'b0;
   endtask : wr

   // ==========
   // Read
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      @(posedge i_clk);
      o_araddr <= a;
      {o_arvalid, o_rready} <= 2'h3;
      do @(posedge i_clk); while (!i_arready);
      o_arvalid <= 1'b0;
      do @(posedge i_clk); while (!i_rvalid);
      d = i_rdata;
      r = i_rresp;
      o_rready <= 1'b0;
   endtask : rd
endmodule : host_axi
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import pll_cfg_pkg::*;
   localparam int CALN = 8;
   // Capacitor pairs {c3, c4} per code, code 0 at the bottom
   localparam logic [191:0] CAPT = {16'h963C, 16'h966E, 16'h643C, 16'h640A,
      16'h32A0, 16'h00A0, 16'h646E, 16'h326E, 16'h006E, 16'h320A, 16'h003C,
      16'h000A};
   logic i_clk, i_rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, ref_in, osc, gate, alock;
   logic lk, lk_oe_n, tick, outs_on, fout_on, slp, cal;
   logic [7:0] awaddr, araddr, c3, c4, rate, rt;
   logic [31:0] wdata, rdata, rv;
   logic [3:0] wstrb, p;
   logic [1:0] bresp, rresp, resp;
   logic [5:0] r3, r4;
   logic [2:0] k3, k4, e;
   logic [17:0] n;
   int errors, n_checks, cyc, ph, ticks;

   pll_cfg_ctrl #(.CAL_CYCLES_P(CALN), .LOCK_SAMPLES(2)) uut (
      .i_clk(i_clk), .i_rst(i_rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
      .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_reference_input(ref_in), .i_osc_pin(osc),
      .i_output_gate_pin(gate), .i_analog_lock(alock), .o_lock_pin(lk),
      .o_lock_pin_oe_n(lk_oe_n), .o_dist_tick(tick),
      .o_outputs_on(outs_on), .o_fout_on(fout_on), .o_device_sleep(slp),
      .o_cal_busy(cal), .o_cap_c3_pf(c3), .o_cap_c4_pf(c4),
      .o_r3_kohm(r3), .o_r4_kohm(r4), .o_reference_rate_mhz(rate));

   host_axi host (.i_clk(i_clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
      .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb),
      .o_wvalid(wvalid), .i_wready(wready), .i_bresp(bresp),
      .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr),
      .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
      .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));

   // ==========
   // Clock, slow pin waveforms, timeout
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   always @(posedge i_clk) begin
      ph <= ph + 1;
      cyc <= cyc + 1;
      if (ph % 3 == 0) osc <= ~osc;
      if (ph % 5 == 0) ref_in <= ~ref_in;
      if (tick === 1'b1) ticks <= ticks + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         finish_test();
      end
   end

   // ==========
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
         input string m);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("unexpected at %0t: %s %0h vs %0h", $time, m, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      if (errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic settle(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask : settle

   function automatic logic [31:0] r14(input logic [11:0] rd,
         input logic [3:0] mx, input logic s, input logic g, input logic f);
      return {3'h0, f, g, s, 2'h0, mx, rd, 8'h00};
   endfunction : r14

   // Lock pin: {pin checked, oe_n, pin}
   function automatic logic [2:0] lk_exp(input logic [3:0] m, input logic a);
      case (m)
         4'h1: return 3'h5;
         4'h2: return 3'h4;
         // Feedback far too slow here, so digital lock reads low
         4'h3: return 3'h4;
         4'h4: return 3'h5;
         4'h9, 4'hB: return 3'h0;
         4'h5: return {2'h2, a};
         4'h6: return {1'b1, a, 1'b0};
         4'h7: return {1'b1, ~a, 1'b1};
         default: return 3'h2;
      endcase
   endfunction : lk_exp

   task automatic tick_test(input int d);
      int t0;
      logic ok;
      t0 = ticks;
      settle(480);
      ok = ticks - t0 >= 80 / d - 1 && ticks - t0 <= 80 / d + 1;
      check(ok, 1, "ticks");
   endtask : tick_test

   // ==========
   // Main sequence
   initial begin
      {i_rst, gate, alock, osc, ref_in} = 5'h18;
      {errors, n_checks, cyc, ph, ticks} = '0;
      void'($urandom(32'hD11DC4A6));
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      settle(6);
      check(rate, RATE_RST, "rate rst");
      check({c3, c4}, 16'h000A, "cap rst");
      check(r3, 0, "r3 rst");
      check(r4, 0, "r4 rst");
      check(lk_oe_n, 1, "pin rst");
      check({outs_on, fout_on, slp, cal}, 4'h8, "ctl rst");
      tick_test(2);
      host.wr(OFS_PRESCALE, 32'h00008000, 4'hF, resp);
      check(resp, RESP_OKAY, "prescale");
      for (int i = 0; i < 12; i++) begin
         k3 = (i == 0) ? 3'h0 : 3'($urandom_range(4, 1));
         k4 = (i == 11) ? 3'h4 : 3'($urandom_range(4));
         rt = 8'($urandom_range(200, 1));
         host.wr(OFS_LOOP, {10'h0, rt, k4, k3, 4'(i), 4'h0}, 4'hF, resp);
         settle(4);
         check({c3, c4}, CAPT[i * 16 +: 16], "cap");
         check(r3, k3 * 10, "r3");
         check(r4, k4 * 10, "r4");
         check(rate, rt, "rate");
      end
      host.wr(OFS_LOOP, 32'h000F0000, 4'h4, resp);
      settle(4);
      check({rate, c3, c4}, {6'h0F, rt[1:0], 16'h963C}, "strb");
      host.wr(8'h20, 32'hFFFFFFFF, 4'hF, resp);
      check(resp, RESP_SLVERR, "unmapped");
      host.wr(OFS_STATUS, 32'h0, 4'hF, resp);
      check({resp, rate}, {RESP_SLVERR, 6'h0F, rt[1:0]}, "ro");
      host.rd(8'h20, rv, resp);
      check(resp, RESP_SLVERR, "rd unmapped");
      host.rd(OFS_LOOP, rv, resp);
      check({resp, rv}, {RESP_OKAY, 32'h0}, "wo read");
      for (int j = 0; j < 16; j++) begin
         host.wr(OFS_REFDIV, r14(12'h00A, 4'h1, j[2], j[0], j[3]), 4'hF, resp);
         @(posedge i_clk);
         gate <= j[1];
         settle(8);
         check(outs_on, j[0] & j[1] & ~j[2], "outs");
         check(fout_on, j[3] & ~j[2], "fout");
         check({slp, lk_oe_n}, {2{j[2]}}, "sleep");
      end
      for (int m = 0; m < 16; m++) begin
         host.wr(OFS_REFDIV, r14(12'h00A, 4'(m), 0, 1, 0), 4'hF, resp);
         for (int a = 0; a < 2; a++) begin
            @(posedge i_clk);
            alock <= a[0];
            settle(6);
            e = lk_exp(4'(m), a[0]);
            check(lk_oe_n, e[1], "pin oe");
            if (e[2] && !e[1]) check(lk, e[0], "pin");
         end
      end
      rv = r14(12'($urandom_range(4095, 1)), 4'h0, 0, 1, 0);
      host.wr(OFS_REFDIV, rv, 4'hF, resp);
      for (int i = 0; i < 3; i++) begin
         p = (i == 0) ? 4'h8 : 4'($urandom_range(8, 2));
         n = (i == 0) ? 18'h3FFFF : 18'($urandom_range(262143, 1));
         host.wr(OFS_FBDIV, {2'h0, p, n, 8'h00}, 4'hF, resp);
         #1;
         check(cal, 1, "cal start");
         settle(CALN - 2);
         check(cal, 1, "cal run");
         settle(1);
         check(cal, 0, "cal end");
         host.rd(OFS_STATUS, rv, resp);
         check(rv & 32'hFF01, 0, "status");
         tick_test(p);
      end
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
